//--- hw/gpb_consts.svh
/*
  Constants for the general purpose I/O block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 50 MHz system clock and a simple strobe register port.
*/
// Summary of operation
// - Four inputs and four outputs, one port each
// - Pending reads one after edge, zero at boot
// - Pin zero edges feed report, not host
// - Level read gives all inputs, pin0 LSB
// - Pin pending read clears only that pin
// - Port pending read clears whole port
// - Input polarity per pin, default active high
// - Edge mode: none, falling, rising, both
// - Read selector holds port and pin, readable
// - Port pending read ignores stored pin index
// - Keyword interrupt input index, read and write
// - Port write loads all outputs at once
// - Pin write changes one output only
// - Output polarity per pin, default active high
// - 500 Hz PWM, 100 steps, percent duty
// - Duty 100 holds output fully on
// - Output from blink LSB, rotated each 100ms
// - Blink write loads one pin's 32-bit pattern
// - Duty and blink act together on one pin
// - Outputs low at boot, driven from the first clock after reset
// - Pending bits sticky until read
`ifndef GPB_CONSTS_SVH
`define GPB_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define GPB_A_RDSEL     8'h00
`define GPB_A_LEVEL     8'h04
`define GPB_A_PEND_PIN  8'h08
`define GPB_A_PEND_PORT 8'h0c
`define GPB_A_IN_POL    8'h10
`define GPB_A_IN_EDGE   8'h14
`define GPB_A_KWD_PIN   8'h18
`define GPB_A_OUT_PORT  8'h1c
`define GPB_A_OUT_PIN   8'h20
`define GPB_A_OUT_POL   8'h24
`define GPB_A_BLINK0    8'h30
`define GPB_A_DUTY0     8'h40

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GPB_F_PIN_LO    0
`define GPB_F_PORT_LO   8
`define GPB_F_VALUE     16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPB_RST_POL     4'hf
`define GPB_RST_EDGE    8'h00
`define GPB_RST_DUTY    7'h64
`define GPB_RST_BLINK   32'hffff_ffff

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define GPB_CLK_HZ      50000000
`define GPB_PWM_HZ      500
`define GPB_PWM_STEPS   100
`define GPB_BLINK_MS    100
`define GPB_PWM_STEP_CYC (`GPB_CLK_HZ / (`GPB_PWM_HZ * `GPB_PWM_STEPS))
`define GPB_BLINK_CYC   (`GPB_BLINK_MS * (`GPB_CLK_HZ / 1000))

`endif

//--- hw/gpb_pkg.sv
/*
  Types for the general purpose I/O block.
  Assumes the constants header supplies all numeric values.
*/
package gpb_pkg;

  // ----------------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;   // Byte address
    logic [31:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } gpb_req_t;

  // Edge event handed to the report generator
  typedef struct packed {
    logic valid;  // One-cycle event pulse
    logic rise;   // 1 rising edge, 0 falling edge
  } gpb_report_t;

  // Stored read selector
  typedef struct packed {
    logic [7:0] port;
    logic [7:0] pin;
  } gpb_sel_t;

endpackage : gpb_pkg

//--- hw/gpb_top.sv
/*
  General purpose I/O block: four inputs with polarity and edge capture,
  four outputs with polarity, PWM and blink pattern.
  Assumes pins synchronous to i_clk_sys and a single-cycle strobe master.
*/
`timescale 1ns/1ps
`include "gpb_consts.svh"

module gpb_top #(
  parameter int unsigned P_BLINK_CYC = `GPB_BLINK_CYC  // Cycles per blink step
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire gpb_pkg::gpb_req_t    i_bus,
  input  wire logic [3:0]           i_gpi,
  output logic [31:0]               o_rdata,
  output logic [3:0]                o_gpo,
  output logic [3:0]                o_gpo_oe,
  output gpb_pkg::gpb_report_t      o_report
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // One-hot pin select; only port 0 with pin 0..3 exists
  function automatic logic [3:0] pin_hot(input logic [7:0] port,
                                         input logic [7:0] pin);
    pin_hot = 4'h0;
    if (port == 8'h00 && pin < 8'h04)
    begin
      pin_hot = 4'h1 << pin[1:0];
    end
  endfunction : pin_hot

  localparam logic [9:0]  PWM_STEP_CYC = 10'(`GPB_PWM_STEP_CYC);
  localparam logic [31:0] BLINK_CYC    = 32'(P_BLINK_CYC);

  // All checks below run on the system clock and sleep during reset
  default clocking ast_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  gpb_pkg::gpb_sel_t rdsel_r;            // Read selector
  logic [3:0]        in_pol_r;           // Input polarity, 1 active high
  logic [7:0]        in_edge_r;          // Two bits per input pin
  logic [1:0]        kwd_pin_r;          // Keyword interrupt input
  logic [3:0]        prev_r;             // Last seen input level
  logic              prime_r;            // prev_r holds a real sample
  logic [3:0]        pend_r;             // Sticky pending bits
  logic [3:0]        out_val_r;          // Written output values
  logic [3:0]        out_pol_r;          // Output polarity
  logic [6:0]        duty_r [4];         // Duty percent per pin
  logic [31:0]       blink_r [4];        // Blink pattern per pin
  logic [9:0]        pre_cnt_r;          // PWM step prescaler
  logic [6:0]        step_r;             // PWM step 0..99
  logic [31:0]       blink_cnt_r;        // Blink interval counter
  logic              blink_tick;         // One-cycle blink step enable
  logic [3:0]        lvl;                // Inputs after polarity
  logic [3:0]        hit;                // Qualified edges this cycle
  logic [3:0]        pend_set;           // Host-visible captures
  logic [3:0]        pend_clr;           // Clears from pending reads
  logic [3:0]        pin_sel_hot;        // Read selector as one-hot
  logic [3:0]        wr_hot;             // Pin write target
  logic [31:0]       rdata_nxt;          // Read mux
  logic              rd_pin, rd_port;    // Pending read strobes

  // ----------------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------------
  // Polarity is applied before edge detection, so edges refer to the
  // active sense of each pin.
  always_comb
  begin
    lvl = ~(i_gpi ^ in_pol_r);
    for (int k = 0; k < 4; k++)
    begin
      hit[k] = prime_r &
               ((in_edge_r[2*k+1] & lvl[k] & ~prev_r[k]) |
                (in_edge_r[2*k]   & ~lvl[k] & prev_r[k]));
    end
    pend_set = hit & 4'he;
  end

  // Previous level; the first sample only primes, so boot makes no edge
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      prev_r  <= 4'h0;
      prime_r <= 1'b0;
    end
    else
    begin
      prev_r  <= lvl;
      prime_r <= 1'b1;
    end
  end

  assign pin_sel_hot = pin_hot(rdsel_r.port, rdsel_r.pin);
  assign rd_pin      = i_bus.rd && i_bus.addr == `GPB_A_PEND_PIN;
  assign rd_port     = i_bus.rd && i_bus.addr == `GPB_A_PEND_PORT;

  // Clears: a pin read clears one bit, a port read clears the port
  always_comb
  begin
    pend_clr = 4'h0;
    if (rd_pin)
    begin
      pend_clr = pin_sel_hot;
    end
    else if (rd_port && rdsel_r.port == 8'h00)
    begin
      pend_clr = 4'hf;
    end
  end

  // Sticky pending; a capture in the clearing cycle survives
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend_r <= 4'h0;
    end
    else
    begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  // Pin zero edges go straight to the report generator
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_report <= '0;
    end
    else
    begin
      o_report.valid <= hit[0];
      o_report.rise  <= lvl[0];
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  assign wr_hot = pin_hot(i_bus.wdata[`GPB_F_PORT_LO +: 8],
                          i_bus.wdata[`GPB_F_PIN_LO +: 8]);

  // Input configuration and selector
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdsel_r   <= '0;
      in_pol_r  <= `GPB_RST_POL;
      in_edge_r <= `GPB_RST_EDGE;
      kwd_pin_r <= 2'h0;
    end
    else if (i_bus.wr)
    begin
      case (i_bus.addr)
        `GPB_A_RDSEL:   rdsel_r   <= i_bus.wdata[15:0];
        `GPB_A_IN_POL:  in_pol_r  <= i_bus.wdata[3:0];
        `GPB_A_IN_EDGE: in_edge_r <= i_bus.wdata[7:0];
        `GPB_A_KWD_PIN: kwd_pin_r <= i_bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  // Output values and polarity; port index other than 0 is ignored
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      out_val_r <= 4'h0;
      out_pol_r <= `GPB_RST_POL;
    end
    else if (i_bus.wr)
    begin
      case (i_bus.addr)
        `GPB_A_OUT_PORT:
        begin
          if (i_bus.wdata[`GPB_F_PORT_LO +: 8] == 8'h00)
          begin
            out_val_r <= i_bus.wdata[3:0];
          end
        end
        `GPB_A_OUT_PIN:
        begin
          out_val_r <= (out_val_r & ~wr_hot) |
                       (wr_hot & {4{i_bus.wdata[`GPB_F_VALUE]}});
        end
        `GPB_A_OUT_POL: out_pol_r <= i_bus.wdata[3:0];
        default: ;
      endcase
    end
  end

  // Duty per pin; low-byte values above 100 are held at 100, upper bits ignored
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 4; k++)
      begin
        duty_r[k] <= `GPB_RST_DUTY;
      end
    end
    else if (i_bus.wr && i_bus.addr[7:4] == 4'(`GPB_A_DUTY0 >> 4) &&
             i_bus.addr[1:0] == 2'h0)
    begin
      duty_r[i_bus.addr[3:2]] <= (i_bus.wdata[7:0] > 8'(`GPB_PWM_STEPS)) ?
                                 `GPB_RST_DUTY : i_bus.wdata[6:0];
    end
  end

  // Blink patterns: a write reloads, a tick rotates right
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 4; k++)
      begin
        blink_r[k] <= `GPB_RST_BLINK;
      end
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (i_bus.wr && i_bus.addr == `GPB_A_BLINK0 + 8'(4 * k))
        begin
          blink_r[k] <= i_bus.wdata;
        end
        else if (blink_tick)
        begin
          blink_r[k] <= {blink_r[k][0], blink_r[k][31:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Timebases
  // ----------------------------------------------------------------------
  // Prescaler makes 100 steps per 2 ms PWM period
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      pre_cnt_r <= 10'h000;
      step_r    <= 7'h00;
    end
    else if (pre_cnt_r == PWM_STEP_CYC - 10'h001)
    begin
      pre_cnt_r <= 10'h000;
      step_r    <= (step_r == 7'(`GPB_PWM_STEPS - 1)) ?
                   7'h00 : step_r + 7'h01;
    end
    else
    begin
      pre_cnt_r <= pre_cnt_r + 10'h001;
    end
  end

  // Blink interval counter; free running, so the phase is not tied to
  // the pattern write
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      blink_cnt_r <= 32'h0000_0000;
    end
    else if (blink_tick)
    begin
      blink_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  assign blink_tick = (blink_cnt_r == BLINK_CYC - 32'h0000_0001);

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  // Value AND blink AND PWM, then polarity; duty 100 never drops
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_gpo    <= 4'h0;
      o_gpo_oe <= 4'h0;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        o_gpo[k] <= ~out_pol_r[k] ^
                    (out_val_r[k] & blink_r[k][0] &
                     (step_r < duty_r[k]));
      end
      o_gpo_oe <= 4'hf;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (i_bus.addr)
      `GPB_A_RDSEL:     rdata_nxt[15:0] = rdsel_r;
      `GPB_A_LEVEL:
        rdata_nxt[3:0] = (rdsel_r.port == 8'h00) ? lvl : 4'h0;
      `GPB_A_PEND_PIN:  rdata_nxt[0] = |(pend_r & pin_sel_hot);
      `GPB_A_PEND_PORT:
        rdata_nxt[3:0] = (rdsel_r.port == 8'h00) ? pend_r : 4'h0;
      `GPB_A_IN_POL:    rdata_nxt[3:0] = in_pol_r;
      `GPB_A_IN_EDGE:   rdata_nxt[7:0] = in_edge_r;
      `GPB_A_KWD_PIN:   rdata_nxt[1:0] = kwd_pin_r;
      `GPB_A_OUT_PORT:  rdata_nxt[3:0] = out_val_r;
      `GPB_A_OUT_POL:   rdata_nxt[3:0] = out_pol_r;
      default:          rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_rdata <= i_bus.rd ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_port_read;
    rd_port && rdsel_r.port == 8'h00 && pend_set == 4'h0;
  endsequence

  sequence s_pin_read;
    rd_pin && pend_set == 4'h0;
  endsequence

  AST_PEND_SET: assert property (
    pend_set != 4'h0 |=> (pend_r & $past(pend_set)) == $past(pend_set))
    else $error("captured edge not held pending");

  AST_PORT_CLR: assert property (
    s_port_read |=> pend_r == 4'h0 && o_rdata[3:0] == $past(pend_r))
    else $error("port pending read wrong or not cleared");

  AST_PIN_CLR: assert property (
    s_pin_read |=> pend_r == ($past(pend_r) & ~$past(pin_sel_hot)))
    else $error("pin pending read cleared wrong bits");

  AST_PIN0_REPORT: assert property (
    hit[0] |=> o_report.valid && !pend_r[0])
    else $error("pin zero edge not handed to report");

  AST_LEVEL_READ: assert property (
    i_bus.rd && i_bus.addr == `GPB_A_LEVEL && rdsel_r.port == 8'h00
    |=> o_rdata[3:0] == $past(lvl))
    else $error("level read mismatch");

  AST_DUTY_FULL: assert property (
    duty_r[1] == 7'h64 && out_val_r[1] && blink_r[1][0] && out_pol_r[1]
    |=> o_gpo[1])
    else $error("full duty did not hold output high");

  AST_DRIVE: assert property (
    !$past(i_rst) |-> o_gpo_oe == 4'hf)
    else $error("outputs not driven");

  AST_ROTATE: assert property (
    blink_tick && !i_bus.wr |=> blink_r[2] == {$past(blink_r[2][0]),
                                               $past(blink_r[2][31:1])})
    else $error("blink pattern did not rotate right");

  AST_PIN_WRITE: assert property (
    i_bus.wr && i_bus.addr == `GPB_A_OUT_PIN
    |=> (out_val_r & ~$past(wr_hot)) == ($past(out_val_r) & ~$past(wr_hot)))
    else $error("pin write disturbed other outputs");

endmodule : gpb_top

//--- tb/gpb_host_model.sv
/*
  Host side of the register port: a single-cycle strobe master.
  Assumes the block answers a read in the cycle after the strobe.
*/
`timescale 1ns/1ps

module gpb_host_model (
  input  wire logic              i_clk_sys,
  input  wire logic [31:0]       i_rdata,
  output gpb_pkg::gpb_req_t      o_bus
);

  // Idle bus at time zero
  initial o_bus = '0;

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  // One-cycle write; idle fields are inverted so stale values never help
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr

  // One-cycle read; data taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    o_bus <= '{addr: ~a, wdata: 32'hffff_ffff, wr: 1'b0, rd: 1'b0};
    #1;
    d = i_rdata;
  endtask : rd

endmodule : gpb_host_model

//--- tb/tb_top.sv
/*
  Self-checking bench for the I/O block: register access, input capture,
  output value, polarity, duty and blink pattern.
  Assumes the host model drives the bus and the bench drives the pins.
*/
`timescale 1ns/1ps
`include "gpb_consts.svh"

module tb_top;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int unsigned BLINK = 20;     // Short blink step
  localparam int          LIMIT = 30000;  // Cycle ceiling for a hang
  logic                   i_clk_sys;
  logic                   i_rst;
  gpb_pkg::gpb_req_t      bus;
  logic [3:0]             gpi;
  logic [31:0]            rdata;
  logic [3:0]             general_output;
  logic [3:0]             gpo_oe;
  gpb_pkg::gpb_report_t   report;
  int                     fail_count = 0;
  int                     tests_run = 0;
  int                     cyc = 0;
  logic [31:0]            rv;
  int                     n;

  // Clock, 20 ns period
  initial i_clk_sys = 1'b0;
  always #10 i_clk_sys = ~i_clk_sys;

  gpb_top #(.P_BLINK_CYC(BLINK)) dut (
    .i_clk_sys (i_clk_sys), .i_rst (i_rst), .i_bus (bus), .i_gpi (gpi),
    .o_rdata (rdata), .o_gpo (general_output), .o_gpo_oe (gpo_oe), .o_report (report)
  );

  gpb_host_model host (
    .i_clk_sys (i_clk_sys), .i_rdata (rdata), .o_bus (bus)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string m);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, rv);
    chk(rv, e, "read data");
  endtask : rdchk

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
  endtask : wait_cyc

  // Cycles in a window where the outputs equal a given value
  task automatic count_eq(input logic [3:0] m, input logic [3:0] v,
                          input int k, output int c);
    c = 0;
    repeat (k)
    begin
      wait_cyc(1);
      if ((general_output & m) === v) c++;
    end
  endtask : count_eq

  // Pin zero edge: expect a one-cycle report pulse within a few cycles
  task automatic pulse_chk(input logic v);
    int hit;
    hit = 0;
    @(posedge i_clk_sys);
    gpi[0] <= v;
    repeat (6)
    begin
      wait_cyc(1);
      if (hit == 0 && report.valid === 1'b1)
      begin
        hit = 1;
        chk(report.rise, v, "report sense");
        wait_cyc(1);
        chk(report.valid, 1'b0, "report one cycle");
      end
    end
    chk(hit, 1, "report pulse");
  endtask : pulse_chk

  task automatic finish_test;
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Hang guard
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fail_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    i_rst = 1'b1;
    gpi   = 4'h0;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    wait_cyc(1);
    // Boot state of outputs and registers
    chk(general_output, 4'h0, "boot level");
    chk(gpo_oe, 4'hf, "drive enable");
    rdchk(`GPB_A_IN_POL, 32'hf);
    rdchk(`GPB_A_OUT_POL, 32'hf);
    rdchk(`GPB_A_IN_EDGE, 32'h0);
    rdchk(`GPB_A_PEND_PORT, 32'h0);
    rdchk(8'h2c, 32'h0);
    wait_cyc(1);
    chk(rdata, 32'h0, "data one cycle");
    // Selector and keyword pin storage
    host.wr(`GPB_A_RDSEL, 32'h0002);
    rdchk(`GPB_A_RDSEL, 32'h0002);
    host.wr(`GPB_A_KWD_PIN, 32'h2);
    rdchk(`GPB_A_KWD_PIN, 32'h2);
    host.wr(`GPB_A_RDSEL, 32'h0000);
    // Level read, then with inverted pins 1 and 3
    @(posedge i_clk_sys);
    gpi <= 4'hd;
    wait_cyc(3);
    rdchk(`GPB_A_LEVEL, 32'hd);
    host.wr(`GPB_A_IN_POL, 32'h5);
    rdchk(`GPB_A_LEVEL, 32'h7);
    host.wr(`GPB_A_IN_POL, 32'hf);
    // Edge modes: pin1 fall, pin2 rise, pin3 both, pin0 off
    @(posedge i_clk_sys);
    gpi <= 4'h0;
    wait_cyc(3);
    host.wr(`GPB_A_IN_EDGE, 32'he4);
    rdchk(`GPB_A_PEND_PORT, 32'h0);
    @(posedge i_clk_sys);
    gpi <= 4'hf;
    wait_cyc(10);
    rdchk(`GPB_A_PEND_PORT, 32'hc);
    rdchk(`GPB_A_PEND_PORT, 32'h0);
    @(posedge i_clk_sys);
    gpi <= 4'h1;
    wait_cyc(10);
    host.wr(`GPB_A_RDSEL, 32'h0001);
    rdchk(`GPB_A_PEND_PIN, 32'h1);
    rdchk(`GPB_A_PEND_PIN, 32'h0);
    rdchk(`GPB_A_PEND_PORT, 32'h8);
    // Pin zero edges go to the report path, never pend
    host.wr(`GPB_A_IN_EDGE, 32'he7);
    pulse_chk(1'b0);
    pulse_chk(1'b1);
    rdchk(`GPB_A_PEND_PORT, 32'h0);
    // Port write, refused port, pin write, output polarity
    host.wr(`GPB_A_OUT_PORT, 32'h0000_000f);
    rdchk(`GPB_A_OUT_PORT, 32'hf);
    wait_cyc(2);
    chk(general_output, 4'hf, "port write");
    host.wr(`GPB_A_OUT_PORT, 32'h0000_0100);
    rdchk(`GPB_A_OUT_PORT, 32'hf);
    host.wr(`GPB_A_OUT_PORT, 32'h0);
    host.wr(`GPB_A_OUT_PIN, 32'h0001_0002);
    wait_cyc(3);
    chk(general_output, 4'h4, "pin write");
    host.wr(`GPB_A_OUT_POL, 32'h3);
    rdchk(`GPB_A_OUT_POL, 32'h3);
    wait_cyc(2);
    chk(general_output, 4'h8, "output polarity");
    host.wr(`GPB_A_OUT_POL, 32'hf);
    // Duty 0 off, 200 clamps to full, 100 full like a plain high
    host.wr(`GPB_A_OUT_PORT, 32'hf);
    host.wr(`GPB_A_DUTY0, 32'd0);
    host.wr(`GPB_A_DUTY0 + 8'h04, 32'd200);
    host.wr(`GPB_A_DUTY0 + 8'h0c, 32'd100);
    wait_cyc(3);
    count_eq(4'hf, 4'he, 1200, n);
    chk(n, 1200, "duty ends");
    // Duty 2 and 3 must fall exactly one PWM step apart; the step
    // counter is still in step 1 here, so both pins start high
    host.wr(`GPB_A_DUTY0, 32'd2);
    host.wr(`GPB_A_DUTY0 + 8'h08, 32'd3);
    wait_cyc(2);
    chk(general_output[0], 1'b1, "duty 2 on");
    n = 0;
    while (n < 2000 && general_output[0] !== 1'b0)
    begin
      wait_cyc(1);
      n++;
    end
    // The sample that saw pin 0 fall still has pin 2 high
    count_eq(4'h4, 4'h4, 1100, n);
    chk(n + 1, `GPB_PWM_STEP_CYC, "duty step");
    host.wr(`GPB_A_DUTY0 + 8'h04, 32'd100);
    // Blink pin1 with pattern bit1: low one step, high one, then low
    host.wr(`GPB_A_BLINK0 + 8'h04, 32'h0000_0002);
    // Let the new pattern reach the pin before looking for the rise
    wait_cyc(1);
    n = 0;
    while (n < 45 && general_output[1] !== 1'b1)
    begin
      wait_cyc(1);
      n++;
    end
    chk(n > 0 && n < 45, 1'b1, "blink rises");
    // The high sample that ended the wait is part of the step
    count_eq(4'h2, 4'h2, 30, n);
    chk(n + 1, BLINK, "blink step");
    count_eq(4'h2, 4'h2, 500, n);
    chk(n, 0, "blink order");
    // Blink and duty together
    host.wr(`GPB_A_BLINK0 + 8'h04, 32'h0000_ffff);
    host.wr(`GPB_A_DUTY0 + 8'h04, 32'd0);
    wait_cyc(3);
    count_eq(4'h2, 4'h2, 32 * BLINK, n);
    chk(n, 0, "blink and duty 0");
    host.wr(`GPB_A_DUTY0 + 8'h04, 32'd100);
    wait_cyc(3);
    count_eq(4'h2, 4'h2, 32 * BLINK, n);
    chk(n, 16 * BLINK, "blink and duty 100");
    chk(gpo_oe, 4'hf, "still driven");
    finish_test();
  end

endmodule : tb_top
